// >>> rtl/ldfc_top.sv
// dimming, strap decode, soft-start current limit and fault supervision
// assumes synchronous inputs, analog sensing reduced to comparator levels
`timescale 1ns/1ns
`default_nettype none
module ldfc_top #(
    parameter int SS_STEP_CYCLES = ldfc_pkg::SS_STEP_CYC_DEF
) (
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    output logic [31:0] HRDATA_OUT,
    input wire logic EN_IN,
    input wire logic DIM_PWM_IN,
    input wire logic RATE_RES_IN,
    input wire logic [7:0] FSW_LEVEL_IN,
    input wire logic [11:0] ISW_MA_IN,
    input wire logic [ldfc_pkg::NCH-1:0] CH_AT_TARGET_IN,
    input wire logic [ldfc_pkg::NCH-1:0] CH_SHORT_IN,
    input wire logic OVP_IN,
    input wire logic OTP_IN,
    input wire logic LED_STABLE_IN,
    output logic GATE_OUT,
    output logic [ldfc_pkg::NCH-1:0] CH_ON_OUT,
    output logic [ldfc_pkg::NCH-1:0] CH_FAULT_OUT,
    output logic [2:0] ILIM_STEP_OUT,
    output logic FSW_1MHZ_OUT,
    output logic PFM_MODE_OUT
);
    import ldfc_pkg::*;

    logic en_q_r;
    logic en_rise;
    logic otp_r;
    logic run;
    ldfc_strap_t strap_r;
    logic dim_q_r;
    logic dim_rise;
    logic [15:0] per_cnt_r;
    logic [15:0] per_last_r;
    logic [16:0] samp_acc_r;
    logic [16:0] samp_sum;
    logic samp_hit;
    logic [8:0] hi_acc_r;
    logic [8:0] duty_r;
    logic [8:0] duty_hold_r;
    logic [15:0] dim_tick_r;
    logic [15:0] tick_cnt_r;
    logic ph_tick;
    logic [7:0] phase_r;
    logic period_wrap;
    logic fault_tick;
    logic [NCH-1:0] lit;
    logic [NCH-1:0] chan_en;
    logic [NCH-1:0] good;
    logic [NCH-1:0] open;
    logic [2:0] ss_step_r;
    logic [23:0] ss_cnt_r;
    logic [5:0] sw_per;
    logic [5:0] sw_cnt_r;
    logic [11:0] ilim;
    logic addr_ok;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rd_word;
    ldfc_status_t status_w;
    ldfc_fault_t fault_w;

    assign en_rise = EN_IN && !en_q_r;
    assign run = en_q_r && !otp_r;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            en_q_r <= 1'b0;
        end else begin
            en_q_r <= EN_IN;
        end
    end

    // straps are looked at once per enable so a noisy divider cannot retune a running boost
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            strap_r <= '0;
        end else if (en_rise) begin
            strap_r <= ldfc_decode(RATE_RES_IN, FSW_LEVEL_IN);
        end
    end

    // set wins over the re-enable clear: a hot die must never restart
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            otp_r <= 1'b0;
        end else if (OTP_IN) begin
            otp_r <= 1'b1;
        end else if (en_rise) begin
            otp_r <= 1'b0;
        end
    end

    // input duty digitiser: 256 evenly spread samples over the last measured period;
    // periods shorter than 256 cycles are outside the input range the host keeps to
    assign dim_rise = DIM_PWM_IN && !dim_q_r;
    assign samp_sum = samp_acc_r + SAMP_INC;
    assign samp_hit = samp_sum >= {1'b0, per_last_r};

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            dim_q_r <= 1'b0;
            per_cnt_r <= 16'h0000;
            per_last_r <= PER_SAT;
        end else begin
            dim_q_r <= DIM_PWM_IN;
            if (dim_rise) begin
                per_cnt_r <= 16'h0000;
                per_last_r <= per_cnt_r;
            end else if (per_cnt_r != PER_SAT) begin
                per_cnt_r <= per_cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN || dim_rise) begin
            samp_acc_r <= 17'h00000;
        end else if (samp_hit) begin
            samp_acc_r <= samp_sum - {1'b0, per_last_r};
        end else begin
            samp_acc_r <= samp_sum;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            hi_acc_r <= 9'h000;
            duty_r <= 9'h000;
        end else if (dim_rise) begin
            hi_acc_r <= 9'h000;
            duty_r <= hi_acc_r;
        end else begin
            if (samp_hit && DIM_PWM_IN && hi_acc_r != DUTY_FULL) begin
                hi_acc_r <= hi_acc_r + 9'h001;
            end
            if (per_cnt_r == PER_SAT) begin
                duty_r <= DIM_PWM_IN ? DUTY_FULL : 9'h000;
            end
        end
    end

    // output dimming period: 256 phase steps of dim_tick_r + 1 cycles each
    assign ph_tick = tick_cnt_r >= dim_tick_r;
    assign period_wrap = ph_tick && phase_r == 8'hff;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            tick_cnt_r <= 16'h0000;
            phase_r <= 8'h00;
            duty_hold_r <= 9'h000;
        end else begin
            tick_cnt_r <= ph_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
            if (ph_tick) begin
                phase_r <= phase_r + 8'h01;
            end
            if (period_wrap) begin
                duty_hold_r <= duty_r;
            end
        end
    end

    // each channel is lit once per period, offset by a quarter period
    always_comb begin
        lit = '0;
        for (int k = 0; k < NCH; k++) begin
            lit[k] = {1'b0, phase_r - 8'(PH_STEP * k)} < duty_hold_r;
        end
    end

    assign fault_tick = strap_r.pass_thru ? dim_rise : period_wrap;

    // each channel keeps its own supervisor, so one fault never touches another
    for (genvar g = 0; g < NCH; g++) begin : g_chan
        ldfc_chan_guard i_ldfc_chan_guard (
            .clk_in(MCLK_IN),
            .nrst_in(NRST_IN),
            .restart_in(en_rise),
            .run_in(run),
            .on_in(CH_ON_OUT[g]),
            .stable_in(LED_STABLE_IN),
            .tick_in(fault_tick),
            .at_target_in(CH_AT_TARGET_IN[g]),
            .short_in(CH_SHORT_IN[g]),
            .ovp_in(OVP_IN),
            .limit_in(strap_r.pass_thru ? TO_DIRECT : TO_PHASE),
            .chan_en_out(chan_en[g]),
            .good_out(good[g]),
            .open_out(open[g])
        );
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN || !run) begin
            CH_ON_OUT <= '0;
        end else if (strap_r.pass_thru) begin
            CH_ON_OUT <= {NCH{DIM_PWM_IN}} & chan_en;
        end else begin
            CH_ON_OUT <= lit & chan_en;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            CH_FAULT_OUT <= '0;
        end else begin
            CH_FAULT_OUT <= en_q_r ? ~chan_en : '0;
        end
    end

    // step timer only runs while a string conducts, which stretches it at low duty
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN || en_rise) begin
            ss_step_r <= 3'h0;
            ss_cnt_r <= 24'h000000;
        end else if (run && ss_step_r != SS_LAST && |CH_ON_OUT) begin
            if (ss_cnt_r == 24'(SS_STEP_CYCLES - 1)) begin
                ss_cnt_r <= 24'h000000;
                ss_step_r <= ss_step_r + 3'h1;
            end else begin
                ss_cnt_r <= ss_cnt_r + 24'h000001;
            end
        end
    end

    assign ilim = ldfc_ilim(ss_step_r);
    assign sw_per = strap_r.fsw_1mhz ? SW_PER_HI : SW_PER_LO;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN || !run) begin
            sw_cnt_r <= 6'h00;
        end else begin
            sw_cnt_r <= (sw_cnt_r == sw_per - 6'h01) ? 6'h00 : sw_cnt_r + 6'h01;
        end
    end

    // pulse skip: with no string conducting there is no load, so the cycle is dropped
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN || !run) begin
            GATE_OUT <= 1'b0;
        end else if (ISW_MA_IN > ilim || sw_cnt_r == sw_per - SW_OFF_MIN) begin
            GATE_OUT <= 1'b0;
        end else if (sw_cnt_r == 6'h00) begin
            GATE_OUT <= !(strap_r.pfm && CH_ON_OUT == '0);
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            ILIM_STEP_OUT <= 3'h0;
            FSW_1MHZ_OUT <= 1'b0;
            PFM_MODE_OUT <= 1'b0;
        end else begin
            ILIM_STEP_OUT <= ss_step_r;
            FSW_1MHZ_OUT <= strap_r.fsw_1mhz;
            PFM_MODE_OUT <= strap_r.pfm;
        end
    end

    // ahb-lite slave, zero wait states, always okay
    assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];

    always_comb begin
        status_w = '0;
        status_w.run = run;
        status_w.ss_step = ss_step_r;
        status_w.otp = otp_r;
        status_w.strap = strap_r;
        fault_w = '0;
        fault_w.fault = CH_FAULT_OUT;
        fault_w.open = open;
        fault_w.good = good;
        case (HADDR_IN[7:0])
            REG_DIM_TICK: rd_word = {16'h0000, dim_tick_r};
            REG_STATUS: rd_word = status_w;
            REG_FAULT: rd_word = fault_w;
            REG_DUTY: rd_word = {23'h000000, duty_r};
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            HRDATA_OUT <= 32'h00000000;
            HREADYOUT_OUT <= 1'b0;
            HRESP_OUT <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok && HWRITE_IN;
            wr_addr_r <= HADDR_IN[7:0];
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
            if (addr_ok && !HWRITE_IN) begin
                HRDATA_OUT <= rd_word;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            dim_tick_r <= DIM_TICK_RST;
        end else if (wr_pend_r && wr_addr_r == REG_DIM_TICK) begin
            dim_tick_r <= HWDATA_IN[15:0];
        end
    end

    a_pass_follow: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (strap_r.pass_thru && run && chan_en[0]) |=> CH_ON_OUT[0] == $past(DIM_PWM_IN))
        else $error("pass-through channel does not follow dimming input");
    a_mode_select: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        en_rise |=> strap_r.pass_thru == !$past(RATE_RES_IN))
        else $error("dimming mode not taken from rate pin at enable");
    a_fsw_low_band: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (en_rise && FSW_LEVEL_IN <= FSW_B1) |=> (strap_r.pfm && !strap_r.fsw_1mhz))
        else $error("lowest strap band not decoded as 600kHz pulse skip");
    a_strap_hold: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        !en_rise |=> $stable(strap_r))
        else $error("strap selection changed without an enable");
    a_ilim_cut: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (ISW_MA_IN > ilim) |=> !GATE_OUT)
        else $error("switch stayed on above the current limit");
    a_ss_restart: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        en_rise |=> (ss_step_r == 3'h0 && ILIM_STEP_OUT == $past(ss_step_r)) ##1 ILIM_STEP_OUT == 3'h0)
        else $error("soft-start did not restart at the lowest limit");
    a_ss_single: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (!en_rise && ss_step_r != SS_LAST) |=> (ss_step_r == $past(ss_step_r)
            || ss_step_r == $past(ss_step_r) + 3'h1))
        else $error("soft-start skipped a step");
    a_otp_off: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        OTP_IN |=> ##1 (CH_ON_OUT == '0 && !GATE_OUT))
        else $error("over-temperature left switching or channels on");
    a_phase_zero: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
        (!strap_r.pass_thru && duty_hold_r == 9'h000 && !period_wrap && !en_rise)
            |=> CH_ON_OUT == '0)
        else $error("zero duty still lit a channel in phase-shift mode");
endmodule
`default_nettype wire

// >>> shared/ldfc_pkg.sv
// constants, types and helpers for the led boost dimming and fault control block
// assumes a single 25 MHz clock and one AHB-Lite master reaching the registers
// Contract
// - pass-through mode drives channels straight from input
// - floating rate pin selects pass-through, resistor phase-shift
// - strap level picks switching frequency and skip mode
// - strap decode still applies in pass-through mode
// - phase-shifted dimming uses 8-bit duty, 0.4% to 100%
// - switch on-phase ends when current exceeds limit
// - current limit starts 225mA, seven 225mA steps
// - steps span about 8ms, longer at low duty
// - faults ignored while led feedback is not stable; the overvoltage open is not gated by stable feedback
// - a faulted channel never disables the others
// - channel above short threshold is disabled
// - channel reaching target current is marked good
// - good channel dropping below target is open
// - overvoltage declares every not-good channel open
// - open declaration disables channel only after time-out
// - zener-bypassed string stays on unless overvoltage reached
// - time-out 6 periods phase mode, 12 pass-through
// - over-temperature stops switching and all channels
`default_nettype none
package ldfc_pkg;
    localparam int NCH = 4;
    localparam int CLK_HZ = 25_000_000;
    localparam int FSW_LO_HZ = 600_000;
    localparam int FSW_HI_HZ = 1_000_000;
    localparam logic [5:0] SW_PER_LO = 6'(CLK_HZ / FSW_LO_HZ);
    localparam logic [5:0] SW_PER_HI = 6'(CLK_HZ / FSW_HI_HZ);
    localparam logic [5:0] SW_OFF_MIN = 6'h03;
    localparam int SS_TOTAL_MS = 8;
    localparam int SS_STEPS = 8;
    localparam int SS_STEP_CYC_DEF = CLK_HZ / 1000 * SS_TOTAL_MS / SS_STEPS;
    localparam logic [2:0] SS_LAST = 3'h7;
    localparam logic [11:0] ILIM_STEP_MA = 12'he1;
    // strap thresholds as fractions of 255, split at the midpoints between bands
    localparam logic [7:0] FSW_B1 = 8'h39;
    localparam logic [7:0] FSW_B2 = 8'h7b;
    localparam logic [7:0] FSW_B3 = 8'hbd;
    localparam logic [3:0] TO_PHASE = 4'h6;
    localparam logic [3:0] TO_DIRECT = 4'hc;
    localparam logic [15:0] DIM_TICK_RST = 16'h0031;
    localparam logic [7:0] PH_STEP = 8'h40;
    localparam logic [8:0] DUTY_FULL = 9'h100;
    localparam logic [15:0] PER_SAT = 16'hffff;
    localparam logic [16:0] SAMP_INC = 17'h00100;
    localparam logic [7:0] REG_DIM_TICK = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAULT = 8'h08;
    localparam logic [7:0] REG_DUTY = 8'h0c;

    typedef struct packed {
        logic pass_thru;
        logic pfm;
        logic fsw_1mhz;
    } ldfc_strap_t;

    typedef struct packed {
        logic [23:0] rsvd;
        logic run;
        logic [2:0] ss_step;
        logic otp;
        ldfc_strap_t strap;
    } ldfc_status_t;

    typedef struct packed {
        logic [19:0] rsvd;
        logic [NCH-1:0] fault;
        logic [NCH-1:0] open;
        logic [NCH-1:0] good;
    } ldfc_fault_t;

    function automatic ldfc_strap_t ldfc_decode(input logic res_attached, input logic [7:0] lvl);
        ldfc_strap_t s;
        s.pass_thru = !res_attached;
        s.pfm = (lvl <= FSW_B1) || (lvl > FSW_B3);
        s.fsw_1mhz = (lvl > FSW_B2);
        return s;
    endfunction

    function automatic logic [11:0] ldfc_ilim(input logic [2:0] step);
        return 12'(ILIM_STEP_MA * ({9'h000, step} + 12'h001));
    endfunction
endpackage
`default_nettype wire

// >>> rtl/ldfc_chan_guard.sv
// one led channel's good/open/short supervision with its disable time-out
// assumes the comparator inputs are synchronous and restart pulses on enable
`timescale 1ns/1ns
`default_nettype none
module ldfc_chan_guard (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic restart_in,
    input wire logic run_in,
    input wire logic on_in,
    input wire logic stable_in,
    input wire logic tick_in,
    input wire logic at_target_in,
    input wire logic short_in,
    input wire logic ovp_in,
    input wire logic [3:0] limit_in,
    output logic chan_en_out,
    output logic good_out,
    output logic open_out
);
    logic good_r;
    logic open_r;
    logic en_r;
    logic [3:0] to_cnt_r;
    logic pending;

    // short only counts while feedback says the loop has settled
    assign pending = open_r || (short_in && stable_in && run_in);

    always_ff @(posedge clk_in) begin
        if (!nrst_in || restart_in) begin
            good_r <= 1'b0;
        end else if (run_in && on_in && at_target_in) begin
            good_r <= 1'b1;
        end
    end

    // a zener-bypassed string still reaches target, so only overvoltage opens it
    always_ff @(posedge clk_in) begin
        if (!nrst_in || restart_in) begin
            open_r <= 1'b0;
        end else if (run_in && ovp_in && !good_r) begin
            open_r <= 1'b1;
        end else if (run_in && good_r && on_in && !at_target_in && stable_in) begin
            open_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in || restart_in || !pending) begin
            to_cnt_r <= 4'h0;
        end else if (tick_in && to_cnt_r != limit_in) begin
            to_cnt_r <= to_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            en_r <= 1'b0;
        end else if (restart_in) begin
            en_r <= 1'b1;
        end else if (pending && to_cnt_r == limit_in) begin
            en_r <= 1'b0;
        end
    end

    assign chan_en_out = en_r;
    assign good_out = good_r;
    assign open_out = open_r;

    a_good_mark: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!restart_in && run_in && on_in && at_target_in) |=> good_r)
        else $error("good flag not set at target current");
    a_ovp_open: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!restart_in && run_in && ovp_in && !good_r) |=> open_r)
        else $error("overvoltage did not open a channel that was not good");
    a_no_early_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (en_r && !restart_in && to_cnt_r != limit_in) |=> en_r)
        else $error("channel disabled before its time-out expired");
    a_timeout_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (open_r && !restart_in && to_cnt_r == limit_in) |=> !en_r)
        else $error("open channel still enabled after time-out");
endmodule
`default_nettype wire

// >>> bench/ldfc_partner.sv
// far side model: host dimming source and the led strings
// assumes the bench sets period, high time and string faults
`timescale 1ns/1ns
`default_nettype none
module ldfc_partner (
    input wire logic clk_in,
    input wire logic [15:0] per_in,
    input wire logic [15:0] high_in,
    input wire logic [3:0] on_in,
    input wire logic [3:0] open_in,
    input wire logic [3:0] short_in,
    output logic dim_out,
    output logic [3:0] at_target_out,
    output logic [3:0] short_out
);
    logic [15:0] cnt = 16'h0000;
    // bench keeps period >= 834 and high >= 12 cycles
    always @(posedge clk_in) begin
        cnt <= (cnt + 16'h0001 >= per_in) ? 16'h0000 : cnt + 16'h0001;
    end
    assign dim_out = cnt < high_in;
    // combinational so a string lit at this edge is already at target
    assign at_target_out = on_in & ~open_in;
    assign short_out = short_in;
endmodule
`default_nettype wire

// >>> bench/ldfc_top_test.sv
// self-checking bench for the dimming, strap, soft-start and fault block
// assumes ldfc_partner plays the host and the led strings
`timescale 1ns/1ns
`default_nettype none
module ldfc_top_test;
    import ldfc_pkg::*;
    localparam int SS = 20;
    localparam int PER = 840;
    localparam int PH = 256 * (3 + 1);
    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0, en = 1'b0, rres = 1'b0;
    logic over_v = 1'b0, otp = 1'b0, stable = 1'b1, hready, hresp, dim, gate, f1m, pfm;
    logic [1:0] htrans = 2'b00;
    logic [7:0] fsw = 8'h00;
    logic [11:0] isw = 12'h000;
    logic [15:0] high = 16'h01a4;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata, rd;
    logic [3:0] open_m = 4'h0, short_m = 4'h0, at_t, shrt, lit, shut;
    logic [2:0] ilim;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    int lvls[8] = '{0, 57, 58, 123, 124, 189, 190, 255};

    ldfc_top #(.SS_STEP_CYCLES(SS)) i_ldfc_top (
        .MCLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata), .EN_IN(en),
        .DIM_PWM_IN(dim), .RATE_RES_IN(rres), .FSW_LEVEL_IN(fsw), .ISW_MA_IN(isw),
        .CH_AT_TARGET_IN(at_t), .CH_SHORT_IN(shrt), .OVP_IN(over_v), .OTP_IN(otp),
        .LED_STABLE_IN(stable), .GATE_OUT(gate), .CH_ON_OUT(lit), .CH_FAULT_OUT(shut),
        .ILIM_STEP_OUT(ilim), .FSW_1MHZ_OUT(f1m), .PFM_MODE_OUT(pfm));
    ldfc_partner i_ldfc_partner (
        .clk_in(clk), .per_in(16'(PER)), .high_in(high), .on_in(lit), .open_in(open_m),
        .short_in(short_m), .dim_out(dim), .at_target_out(at_t), .short_out(shrt));

    initial begin
        forever #20 clk = ~clk;
    end

    // expected {skip mode, 1MHz} for a strap level out of 255
    function automatic logic [1:0] strap(input int lv);
        return {lv <= 57 || lv > 189, lv > 123};
    endfunction

    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic enable(input logic [7:0] lvl, input logic res);
        en <= 1'b0;
        cyc(2);
        fsw <= lvl;
        rres <= res;
        en <= 1'b1;
        cyc(4);
    endtask

    task automatic rises(input int n);
        logic p;
        p = dim;
        while (n > 0) begin
            @(posedge clk);
            if (dim && !p) n--;
            p = dim;
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        int lv, run, mrun, gap, h;
        logic [2:0] last;
        logic p;
        void'($urandom(32'hd754378d));
        cyc(3);
        nrst <= 1'b1;
        bus(1'b0, REG_DIM_TICK, 32'h0);
        check(rd, 32'h00000031);
        check({31'h0, hresp}, 32'h0);
        bus(1'b1, REG_DIM_TICK, 32'h00000003);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 9; i++) begin
            lv = (i < 8) ? lvls[i] : $urandom_range(255);
            enable(8'(lv), i[0]);
            check({30'h0, pfm, f1m}, {30'h0, strap(lv)});
            bus(1'b0, REG_STATUS, 32'h0);
            check({29'h0, rd[2:0]}, {29'h0, !i[0], strap(lv)});
            fsw <= ~fsw;
            rres <= ~rres;
            cyc(3);
            check({30'h0, pfm, f1m}, {30'h0, strap(lv)});
        end
        // sensed current jumps over the limit once the switch closes, so pulses end at once
        high <= 16'(PER);
        enable(8'h96, 1'b0);
        check({29'h0, ilim}, 32'h0);
        last = 3'h0;
        gap = 0;
        run = 0;
        mrun = 0;
        repeat (9 * SS + 20) begin
            @(posedge clk);
            isw <= gate ? 12'h709 + 12'($urandom_range(1000)) : 12'h000;
            run = gate ? run + 1 : 0;
            mrun = (run > mrun) ? run : mrun;
            if (ilim !== last) begin
                check({29'h0, ilim}, {29'h0, last + 3'h1});
                if (last != 3'h0) check(gap, SS);
                last = ilim;
                gap = 0;
            end
            gap++;
        end
        check({29'h0, ilim}, 32'h7);
        check(mrun inside {[1:2]}, 1);
        h = $urandom_range(12, PER - 12);
        high <= 16'(h);
        cyc(1);
        isw <= 12'h000;
        p = dim;
        repeat (3 * PER) begin
            @(posedge clk);
            check({28'h0, lit}, {28'h0, {4{p}}});
            p = dim;
        end
        high <= 16'h01a4;
        rises(1);
        cyc(200);
        bus(1'b0, REG_FAULT, 32'h0);
        check({28'h0, rd[3:0]}, 32'hf);
        short_m <= 4'h2;
        open_m <= 4'h4;
        cyc(3);
        bus(1'b0, REG_FAULT, 32'h0);
        check({24'h0, rd[11:4]}, 32'h04);
        rises(11);
        cyc(100);
        check({28'h0, shut}, 32'h0);
        rises(1);
        cyc(10);
        check({28'h0, shut}, 32'h6);
        check({28'h0, lit}, 32'h9);
        // a short while feedback is unsettled must never count
        short_m <= 4'h8;
        open_m <= 4'h0;
        stable <= 1'b0;
        enable(8'h96, 1'b0);
        rises(14);
        check({28'h0, shut}, 32'h0);
        stable <= 1'b1;
        short_m <= 4'h0;
        otp <= 1'b1;
        cyc(2);
        repeat (40) begin
            @(posedge clk);
            check({27'h0, gate, lit}, 32'h0);
        end
        bus(1'b0, REG_STATUS, 32'h0);
        check({31'h0, rd[3]}, 32'h1);
        otp <= 1'b0;
        // no string ever reaches target, so overvoltage must open all four
        open_m <= 4'hf;
        h = $urandom_range(12, PER - 12);
        high <= 16'(h);
        enable(8'h00, 1'b1);
        over_v <= 1'b1;
        cyc(2);
        over_v <= 1'b0;
        bus(1'b0, REG_FAULT, 32'h0);
        check({28'h0, rd[7:4]}, 32'hf);
        cyc(5 * PH - 30);
        check({28'h0, shut}, 32'h0);
        bus(1'b0, REG_DUTY, 32'h0);
        check(rd - 32'(h * 256 / PER) + 32'h2 <= 32'h4, 1);
        cyc(PH + 60);
        check({28'h0, shut}, 32'hf);
        give_verdict();
    end
endmodule
`default_nettype wire
